/* src/hbi_host_port.sv */
// parallel host port: pin-level bus slave feeding the device register file
//
// Overview of operation
// - Accesses only while chip select is low; strobes ignored otherwise.
// - Separate strobes: read strobe means read, write strobe write.
// - Data strobe: device drives reads while strobe held; host writes.
// - Data-strobe style: direction line tells read from write.
// - Latch passes the address while strobe high, holds at falling edge.
// - Strobe tied low: data-strobe style; tied high: separate strobes.
// - Width low: 8-bit; high: 16-bit, upper byte on port pins.
// - Interrupt follows requests; push-pull either level or open drain.
// - Demultiplexed buses work in both styles; multiplexed ones only with separate strobes.
// - While system reset pin is active the device stays in reset state.
`default_nettype none
module hbi_host_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host bus pins
  input wire logic cs_n,
  input wire logic rd_n_data_strobe_n,
  input wire logic wr_n_read_write,
  input wire logic ale,
  input wire logic bus_width_select,
  input wire logic [hbi_pkg::ADDR_W-1:0] addr_pin,
  input wire logic [hbi_pkg::BYTE_W-1:0] data_lo_in,
  output logic [hbi_pkg::BYTE_W-1:0] data_lo_out,
  output logic data_lo_oe,
  input wire logic [hbi_pkg::BYTE_W-1:0] data_hi_in,
  output logic [hbi_pkg::BYTE_W-1:0] data_hi_out,
  output logic data_hi_oe,
  input wire logic sys_reset,
  // interrupt pin and its configuration
  input wire logic irq_event,
  input wire logic irq_open_drain,
  input wire logic irq_active_high,
  output logic interrupt_request_out,
  output logic interrupt_request_oe,
  // device register file side
  output logic [hbi_pkg::ADDR_W-1:0] reg_addr,
  output logic [hbi_pkg::WORD_W-1:0] reg_wdata,
  output logic reg_wide,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [hbi_pkg::WORD_W-1:0] reg_rdata,
  output logic dev_reset
);
  // ----------------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------------
  typedef struct packed {
    hbi_pkg::hbi_state_t st;
    logic ale_hi_seen;
    logic mux_seen;
    logic ale_prev;
    logic [hbi_pkg::ADDR_W-1:0] latch_addr;
    logic [hbi_pkg::ADDR_W-1:0] addr;
    logic wide;
    logic [hbi_pkg::WORD_W-1:0] wdata;
    logic [hbi_pkg::WORD_W-1:0] dout;
    logic lo_oe;
    logic hi_oe;
    logic rd;
    logic wr;
    logic irq_out;
    logic irq_oe;
    logic dev_rst;
  } hbi_port_state_t;

  hbi_port_state_t cur_r;
  hbi_port_state_t cur_nxt;

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  hbi_sync_if #(.W(hbi_pkg::PIN_W)) pins ();

  assign pins.raw = {data_hi_in, data_lo_in, addr_pin, sys_reset,
                     bus_width_select, ale, wr_n_read_write,
                     rd_n_data_strobe_n, cs_n};

  hbi_pin_sync #(
    .W(hbi_pkg::PIN_W),
    .INIT(hbi_pkg::PIN_RST)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .sif(pins)
  );

  logic cs_n_c;
  logic rd_c;
  logic wr_c;
  logic ale_c;
  logic width_c;
  logic sysrst_c;
  logic [hbi_pkg::ADDR_W-1:0] addr_c;
  logic [hbi_pkg::WORD_W-1:0] din_c;
  logic style_ds;

  // filtered pin levels
  assign cs_n_c = pins.clean[hbi_pkg::P_CS_N];
  assign rd_c = pins.clean[hbi_pkg::P_RD_N];
  assign wr_c = pins.clean[hbi_pkg::P_WR_N];
  assign ale_c = pins.clean[hbi_pkg::P_ALE];
  assign width_c = pins.clean[hbi_pkg::P_WIDTH];
  assign sysrst_c = pins.clean[hbi_pkg::P_SYSRST];
  assign addr_c = pins.clean[hbi_pkg::P_ADDR +: hbi_pkg::ADDR_W];
  assign din_c = pins.clean[hbi_pkg::P_DLO +: hbi_pkg::WORD_W];

  // style from strobe level
  // ale high even once means the separate-strobe style; a host in the
  // data-strobe style never raises it
  assign style_ds = ~cur_r.ale_hi_seen;

  // ----------------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------------
  // returns {read request, write request} for the current pin levels
  function automatic logic [1:0] hbi_req(
    input logic ds_style,
    input logic sel_n,
    input logic strobe_a_n,
    input logic strobe_b
  );
    logic [1:0] r;
    r = 2'h0;
    if (!sel_n) begin
      if (ds_style) begin
        // strobe_b is the direction line: high reads, low writes
        r = {~strobe_a_n & strobe_b, ~strobe_a_n & ~strobe_b};
      end else begin
        // strobe_b is the active-low write strobe
        r = {~strobe_a_n & strobe_b, strobe_a_n & ~strobe_b};
      end
    end
    return r;
  endfunction

  logic [1:0] req;
  logic rd_req;
  logic wr_req;

  assign req = hbi_req(style_ds, cs_n_c, rd_c, wr_c);
  assign rd_req = req[1];
  assign wr_req = req[0];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.rd = 1'b0;
    cur_nxt.wr = 1'b0;
    cur_nxt.ale_prev = ale_c;
    cur_nxt.dev_rst = sysrst_c;
    if (ale_c) begin
      cur_nxt.ale_hi_seen = 1'b1;
    end
    // falling latch strobe
    // a falling edge proves the address shares the data pins
    if (cur_r.ale_prev && !ale_c) begin
      cur_nxt.mux_seen = 1'b1;
    end
    if (ale_c) begin
      cur_nxt.latch_addr = addr_c;
    end

    if (irq_open_drain) begin
      cur_nxt.irq_out = 1'b0;
      cur_nxt.irq_oe = irq_event;
    end else begin
      cur_nxt.irq_out = irq_event ~^ irq_active_high;
      cur_nxt.irq_oe = 1'b1;
    end

    case (cur_r.st)
      hbi_pkg::HBI_IDLE: begin
        cur_nxt.lo_oe = 1'b0;
        cur_nxt.hi_oe = 1'b0;
        cur_nxt.addr = cur_r.mux_seen ? cur_r.latch_addr : addr_c;
        cur_nxt.wide = width_c;
        if (rd_req) begin
          cur_nxt.rd = 1'b1;
          cur_nxt.st = hbi_pkg::HBI_RD_WAIT;
        end else if (wr_req) begin
          cur_nxt.wdata = din_c;
          cur_nxt.st = hbi_pkg::HBI_WR_HOLD;
        end
      end
      hbi_pkg::HBI_RD_WAIT: begin
        // register file answers in the same cycle as the read pulse
        // drive read data
        cur_nxt.dout = reg_rdata;
        cur_nxt.lo_oe = rd_req;
        cur_nxt.hi_oe = rd_req & cur_r.wide;
        cur_nxt.st = rd_req ? hbi_pkg::HBI_RD_DRIVE : hbi_pkg::HBI_IDLE;
      end
      hbi_pkg::HBI_RD_DRIVE: begin
        // release the bus as soon as the strobe or select goes away
        if (!rd_req) begin
          cur_nxt.lo_oe = 1'b0;
          cur_nxt.hi_oe = 1'b0;
          cur_nxt.st = hbi_pkg::HBI_IDLE;
        end
      end
      hbi_pkg::HBI_WR_HOLD: begin
        // write ends on strobe release
        // data is tracked while the strobe is held; the last sample wins
        if (wr_req) begin
          cur_nxt.wdata = din_c;
        end else begin
          cur_nxt.wr = 1'b1;
          cur_nxt.st = hbi_pkg::HBI_IDLE;
        end
      end
      default: begin
        cur_nxt.st = hbi_pkg::HBI_IDLE;
      end
    endcase

    // system reset pin
    // the pin holds everything idle but keeps the style knowledge
    if (sysrst_c) begin
      cur_nxt.st = hbi_pkg::HBI_IDLE;
      cur_nxt.rd = 1'b0;
      cur_nxt.wr = 1'b0;
      cur_nxt.lo_oe = 1'b0;
      cur_nxt.hi_oe = 1'b0;
      cur_nxt.irq_oe = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_r.st <= hbi_pkg::HBI_IDLE;
      cur_r.ale_hi_seen <= hbi_pkg::RST_ALE_HI;
      cur_r.mux_seen <= hbi_pkg::RST_MUX;
      cur_r.ale_prev <= hbi_pkg::RST_ALE_HI;
      cur_r.latch_addr <= hbi_pkg::RST_ADDR;
      cur_r.addr <= hbi_pkg::RST_ADDR;
      cur_r.wide <= 1'b0;
      cur_r.wdata <= hbi_pkg::RST_WORD;
      cur_r.dout <= hbi_pkg::RST_WORD;
      cur_r.lo_oe <= 1'b0;
      cur_r.hi_oe <= 1'b0;
      cur_r.rd <= 1'b0;
      cur_r.wr <= 1'b0;
      cur_r.irq_out <= 1'b0;
      cur_r.irq_oe <= 1'b0;
      cur_r.dev_rst <= hbi_pkg::RST_DEV;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------------
  // upper byte on port pins
  assign data_lo_out = cur_r.dout[hbi_pkg::BYTE_W-1:0];
  assign data_hi_out = cur_r.dout[hbi_pkg::WORD_W-1:hbi_pkg::BYTE_W];
  assign data_lo_oe = cur_r.lo_oe;
  assign data_hi_oe = cur_r.hi_oe;
  assign interrupt_request_out = cur_r.irq_out;
  assign interrupt_request_oe = cur_r.irq_oe;
  assign reg_addr = cur_r.addr;
  assign reg_wdata = cur_r.wdata;
  assign reg_wide = cur_r.wide;
  assign reg_wr = cur_r.wr;
  assign reg_rd = cur_r.rd;
  assign dev_reset = cur_r.dev_rst;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // no access without select
  AST_CS_GATES: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cur_r.st == hbi_pkg::HBI_IDLE && cs_n_c) |=> !reg_rd && !reg_wr
  ) else $error("access started without chip select");

  AST_SEP_READ: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cur_r.st == hbi_pkg::HBI_IDLE && !style_ds && !cs_n_c && !rd_c
     && wr_c && !sysrst_c) |=> reg_rd ##1 !reg_rd
  ) else $error("separate-strobe read not issued as one pulse");

  // read data driven while strobe held
  AST_DS_DRIVE: assert property (
    @(posedge ref_clk) disable iff (rst)
    (reg_rd && !sysrst_c) ##1 (rd_req && !sysrst_c)[*2] |-> data_lo_oe
  ) else $error("read data not driven during strobe");

  AST_DS_DIR: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cur_r.st == hbi_pkg::HBI_IDLE && style_ds && !cs_n_c && !rd_c
     && !wr_c && !sysrst_c) |=> cur_r.st == hbi_pkg::HBI_WR_HOLD
  ) else $error("data-strobe write not taken");

  AST_LATCH: assert property (
    @(posedge ref_clk) disable iff (rst)
    ale_c |=> cur_r.latch_addr == $past(addr_c)
  ) else $error("address latch not transparent");

  // high strobe level forces separate style
  AST_STYLE: assert property (
    @(posedge ref_clk) disable iff (rst)
    ale_c |=> !style_ds
  ) else $error("style not switched to separate strobes");

  // narrow accesses leave port pins alone
  AST_WIDTH: assert property (
    @(posedge ref_clk) disable iff (rst)
    !reg_wide |-> !data_hi_oe
  ) else $error("upper byte driven in 8-bit access");

  // open drain pulls only on request
  AST_IRQ_OD: assert property (
    @(posedge ref_clk) disable iff (rst)
    (irq_open_drain && !sysrst_c) |=> interrupt_request_oe == $past(irq_event)
      && !interrupt_request_out
  ) else $error("open-drain interrupt drive wrong");

  AST_SYSRST: assert property (
    @(posedge ref_clk) disable iff (rst)
    sysrst_c |=> dev_reset && !data_lo_oe && !reg_rd && !reg_wr
  ) else $error("port active during system reset");

  AST_DEMUX_ADDR: assert property (
    @(posedge ref_clk) disable iff (rst)
    (cur_r.st == hbi_pkg::HBI_IDLE && !cur_r.mux_seen)
      |=> reg_addr == $past(addr_c)
  ) else $error("demultiplexed address not taken from pins");
endmodule
`default_nettype wire

/* src/hbi_pkg.sv */
// shared constants and types of the parallel host port
`default_nettype none
package hbi_pkg;
  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int PIN_W = 27;

  // ----------------------------------------------------------------------
  // bit positions inside the synchronised pin vector
  // ----------------------------------------------------------------------
  localparam int P_CS_N = 0;
  localparam int P_RD_N = 1;
  localparam int P_WR_N = 2;
  localparam int P_ALE = 3;
  localparam int P_WIDTH = 4;
  localparam int P_SYSRST = 5;
  localparam int P_ADDR = 6;
  localparam int P_DLO = 11;
  localparam int P_DHI = 19;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  // select and both strobes idle high, everything else low
  localparam logic [PIN_W-1:0] PIN_RST = 27'h0000007;
  localparam logic RST_ALE_HI = 1'b0;
  localparam logic RST_MUX = 1'b0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 5'h00;
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic RST_DEV = 1'b1;

  // ----------------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    HBI_IDLE = 4'h1,
    HBI_RD_WAIT = 4'h2,
    HBI_RD_DRIVE = 4'h4,
    HBI_WR_HOLD = 4'h8
  } hbi_state_t;
endpackage
`default_nettype wire

/* src/hbi_sync_if.sv */
// raw pin vector in, filtered pin vector out, between port and synchroniser
`default_nettype none
interface hbi_sync_if #(
  parameter int W = 27
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport syn (input raw, output clean);
  modport usr (output raw, input clean);
endinterface
`default_nettype wire

/* src/hbi_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`default_nettype none
module hbi_pin_sync #(
  parameter int W = 27,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins in, filtered levels out
  hbi_sync_if.syn sif
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } hbi_sync_state_t;

  hbi_sync_state_t cur_r;
  hbi_sync_state_t cur_nxt;

  // s1 only feeds s2; a bit moves to q once s2 and s3 agree on it
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.s1 = sif.raw;
    cur_nxt.s2 = cur_r.s1;
    cur_nxt.s3 = cur_r.s2;
    for (int i = 0; i < W; i++) begin
      if (cur_r.s2[i] == cur_r.s3[i]) begin
        cur_nxt.q[i] = cur_r.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_r <= {INIT, INIT, INIT, INIT};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign sif.clean = cur_r.q;
endmodule
`default_nettype wire

/* verification/hbi_host_model.sv */
// host-side bus master model driving the parallel host port pins
`default_nettype none
module hbi_host_model (
  // clock
  input wire logic ref_clk,
  // pins driven by the host
  output logic cs_n,
  output logic strobe_a_n,
  output logic strobe_b,
  output logic ale,
  output logic [4:0] addr_pin,
  output logic [15:0] drv,
  // resolved data bus as the host sees it
  input wire logic [15:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mux_r = 1'b0;
  logic [4:0] a_r = 5'h00;

  // multiplexed hosts tie address pins to data
  assign addr_pin = mux_r ? bus[4:0] : a_r;

  // both strobes idle high, address strobe low, select off
  initial begin
    cs_n = 1'b1;
    strobe_a_n = 1'b1;
    strobe_b = 1'b1;
    ale = 1'b0;
    drv = 16'h0000;
  end

  task automatic set_ale(input logic v);
    ale <= v;
  endtask

  // one access; strobe held well past the pin filter latency
  task automatic xfer(input logic sep, input logic mux, input logic wr,
    input logic sel, input logic [4:0] a, input logic [15:0] d,
    output logic [15:0] q);
    mux_r <= mux;
    a_r <= a;
    // address pulse on the data lines
    if (mux) begin
      drv <= {11'h000, a};
      ale <= 1'b1;
      repeat (6) @(posedge ref_clk);
      ale <= 1'b0;
      repeat (6) @(posedge ref_clk);
    end
    drv <= wr ? d : ~drv;
    cs_n <= ~sel;
    strobe_a_n <= sep ? wr : 1'b0;
    strobe_b <= ~wr;
    repeat (12) @(posedge ref_clk);
    q = bus;
    cs_n <= 1'b1;
    strobe_a_n <= 1'b1;
    strobe_b <= 1'b1;
    // released lines must not keep the last value
    drv <= ~drv;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* verification/host_bus_interface_tb.sv */
// self-checking bench for the parallel host port
`default_nettype none
module host_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sys_reset = 1'b0;
  logic bus_width_select = 1'b0;
  logic irq_event = 1'b0;
  logic irq_open_drain = 1'b0;
  logic irq_active_high = 1'b1;
  logic [15:0] reg_rdata;
  logic cs_n, sa_n, sb, ale, lo_oe, hi_oe, irq_out, irq_oe;
  logic reg_wide, reg_wr, reg_rd, dev_reset, ww;
  logic hi_seen = 1'b0;
  logic [4:0] addr_pin, reg_addr, wa;
  logic [7:0] lo_out, hi_out;
  logic [15:0] drv, bus, reg_wdata, wd, q;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_wr = 0;
  int n_rd = 0;

  always #2.5 ref_clk = ~ref_clk;

  // device drive wins over the host's released lines
  assign bus[7:0] = lo_oe ? lo_out : drv[7:0];
  assign bus[15:8] = hi_oe ? hi_out : drv[15:8];

  hbi_host_port hbi_host_port_inst (
    .ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
    .rd_n_data_strobe_n(sa_n), .wr_n_read_write(sb), .ale(ale),
    .bus_width_select(bus_width_select), .addr_pin(addr_pin),
    .data_lo_in(bus[7:0]), .data_lo_out(lo_out), .data_lo_oe(lo_oe),
    .data_hi_in(bus[15:8]), .data_hi_out(hi_out), .data_hi_oe(hi_oe),
    .sys_reset(sys_reset), .irq_event(irq_event),
    .irq_open_drain(irq_open_drain), .irq_active_high(irq_active_high),
    .interrupt_request_out(irq_out), .interrupt_request_oe(irq_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wide(reg_wide),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dev_reset(dev_reset));

  hbi_host_model hbi_host_model_inst (
    .ref_clk(ref_clk), .cs_n(cs_n), .strobe_a_n(sa_n), .strobe_b(sb),
    .ale(ale), .addr_pin(addr_pin), .drv(drv), .bus(bus));

  // register file stand-in: distinct halves so byte swaps show
  function automatic logic [15:0] rd_val(input logic [4:0] a);
    return {3'h5, a, ~a, 3'h2};
  endfunction

  // the port samples read data at the edge that ends its read pulse, so
  // the stand-in answers from the current address with no register stage
  assign reg_rdata = rd_val(reg_addr);

  // ---------------------------------------------------------------
  // monitors
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (reg_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      wa <= reg_addr;
      wd <= reg_wdata;
      ww <= reg_wide;
    end
    if (reg_rd === 1'b1) begin
      n_rd <= n_rd + 1;
    end
    if (hi_oe === 1'b1) begin
      hi_seen <= 1'b1;
    end
  end

  // hang guard
  always @(posedge ref_clk) begin
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ---------------------------------------------------------------
  // access helpers
  // ---------------------------------------------------------------
  task automatic do_wr(input logic sep, input logic mux, input logic wide,
    input logic [4:0] a, input logic [15:0] d);
    int b;
    logic [15:0] m;
    b = n_wr;
    m = wide ? 16'hffff : 16'h00ff;
    bus_width_select <= wide;
    hbi_host_model_inst.xfer(sep, mux, 1'b1, 1'b1, a, d, q);
    chk("write count", 16'(b + 1), 16'(n_wr));
    chk("write addr", {11'h000, a}, {11'h000, wa});
    chk("write data", d & m, wd & m);
    chk("write width", {15'h0000, wide}, {15'h0000, ww});
  endtask

  task automatic do_rd(input logic sep, input logic mux, input logic wide,
    input logic [4:0] a);
    int b;
    logic [15:0] m;
    b = n_rd;
    m = wide ? 16'hffff : 16'h00ff;
    bus_width_select <= wide;
    hi_seen <= 1'b0;
    hbi_host_model_inst.xfer(sep, mux, 1'b0, 1'b1, a, 16'h0000, q);
    chk("read count", 16'(b + 1), 16'(n_rd));
    chk("read data", rd_val(a) & m, q & m);
    chk("upper drive", {15'h0000, wide}, {15'h0000, hi_seen});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    repeat (8) @(posedge ref_clk);
    chk("reset dev", 16'h0001, {15'h0000, dev_reset});
    chk("reset oe", 16'h0000, {14'h0000, lo_oe, irq_oe});
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("dev after reset", 16'h0000, {15'h0000, dev_reset});
  endtask

  // address strobe low since reset: data-strobe style, demultiplexed
  task automatic t_dstrobe();
    do_wr(1'b0, 1'b0, 1'b0, 5'h0a, 16'h005c);
    do_rd(1'b0, 1'b0, 1'b0, 5'h13);
    do_wr(1'b0, 1'b0, 1'b1, 5'h1f, 16'ha53c);
    do_rd(1'b0, 1'b0, 1'b1, 5'h07);
  endtask

  task automatic t_unselected();
    int bw;
    int br;
    bw = n_wr;
    br = n_rd;
    hbi_host_model_inst.xfer(1'b0, 1'b0, 1'b1, 1'b0, 5'h03, 16'h00ff, q);
    hbi_host_model_inst.xfer(1'b0, 1'b0, 1'b0, 1'b0, 5'h03, 16'h0000, q);
    chk("unsel writes", 16'(bw), 16'(n_wr));
    chk("unsel reads", 16'(br), 16'(n_rd));
  endtask

  // strobe held high switches to separate strobes, still demultiplexed
  task automatic t_separate();
    hbi_host_model_inst.set_ale(1'b1);
    repeat (8) @(posedge ref_clk);
    do_wr(1'b1, 1'b0, 1'b0, 5'h11, 16'h0069);
    do_rd(1'b1, 1'b0, 1'b1, 5'h04);
  endtask

  // address pins follow the data bus, so only the latch holds it
  task automatic t_mux();
    do_wr(1'b1, 1'b1, 1'b0, 5'h15, 16'h003a);
    do_rd(1'b1, 1'b1, 1'b1, 5'h0e);
  endtask

  task automatic t_irq();
    logic od;
    logic ah;
    logic ev;
    for (int i = 0; i < 8; i++) begin
      {od, ah, ev} = 3'(i);
      irq_open_drain <= od;
      irq_active_high <= ah;
      irq_event <= ev;
      repeat (3) @(posedge ref_clk);
      chk("irq level", {15'h0000, ~od & ~(ev ^ ah)},
        {15'h0000, irq_out});
      chk("irq enable", {15'h0000, od ? ev : 1'b1},
        {15'h0000, irq_oe});
    end
  endtask

  task automatic t_sysrst();
    int br;
    sys_reset <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("sys dev", 16'h0001, {15'h0000, dev_reset});
    chk("sys irq oe", 16'h0000, {15'h0000, irq_oe});
    br = n_rd;
    hbi_host_model_inst.xfer(1'b1, 1'b1, 1'b0, 1'b1, 5'h02, 16'h0000, q);
    chk("sys reads", 16'(br), 16'(n_rd));
    sys_reset <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("sys release", 16'h0000, {15'h0000, dev_reset});
  endtask

  initial begin
    t_reset();
    t_dstrobe();
    t_unselected();
    t_separate();
    t_mux();
    t_irq();
    t_sysrst();
    end_sim();
  end
endmodule
`default_nettype wire
